//--- hdl/iox_pkg.sv
// shared constants and types of the i/o expander port logic
package iox_pkg;
  // ==========================================================================
  // register indices; the byte address on apb is four times the index
  localparam logic [3:0] IDX_DIR       = 4'h0;
  localparam logic [3:0] IDX_POLARITY  = 4'h1;
  localparam logic [3:0] IDX_CHG_EN    = 4'h2;
  localparam logic [3:0] IDX_CMP_DEF   = 4'h3;
  localparam logic [3:0] IDX_CMP_MODE  = 4'h4;
  localparam logic [3:0] IDX_DEV_CFG   = 4'h5;
  localparam logic [3:0] IDX_PULLUP    = 4'h6;
  localparam logic [3:0] IDX_INT_FLAG  = 4'h7;
  localparam logic [3:0] IDX_INT_CAP   = 4'h8;
  localparam logic [3:0] IDX_PORT      = 4'h9;
  localparam logic [3:0] IDX_OUT_LATCH = 4'ha;
  localparam logic [3:0] IDX_LAST      = 4'ha;
  // block status registers, byte addresses
  localparam logic [7:0] OFS_EVT_STATUS = 8'h40;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h44;
  localparam logic [7:0] OFS_ADDR_CODE  = 8'h48;
  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_REG = 8'h00;
  // device configuration bit positions
  localparam int CFG_INT_POL   = 1;
  localparam int CFG_INT_ODR   = 2;
  localparam int CFG_SEQ_OFF   = 5;
  // event status bit positions
  localparam int EVT_PIN_INT   = 0;
  localparam int EVT_LINK_WR   = 1;
  localparam int EVT_DISCARD   = 2;
  localparam int EVT_WIDTH     = 3;
  // fixed upper nibble of the serial opcode
  localparam logic [3:0] OPCODE_PREFIX = 4'h4;
  // ==========================================================================
  // serial frame phase
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_ADDR   = 2'b01,
    PH_DATA   = 2'b10,
    PH_IGNORE = 2'b11
  } iox_phase_type;
endpackage

//--- hdl/iox_sampler.sv
// two-flop synchronisers for every pin input and edge finding on the link clock
module iox_sampler
  import iox_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       reset_pin_n_i,
  input  wire logic [2:0] addr_sel_i,
  input  wire logic [7:0] port_pin_i,
  output logic            sck_rise_o,
  output logic            sck_fall_o,
  output logic            cs_n_o,
  output logic            si_o,
  output logic            reset_pin_n_o,
  output logic [2:0]      addr_sel_o,
  output logic [7:0]      port_pin_o
);
  localparam int W = 15;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic         sck_last;
  } iox_smp_type;

  iox_smp_type s_reg;
  iox_smp_type s_next;

  // ==========================================================================
  // meta feeds only sync; the edge finder looks at sync and its delayed copy
  always_comb begin
    s_next          = s_reg;
    s_next.meta     = {port_pin_i, addr_sel_i, reset_pin_n_i, si_i, cs_n_i, sck_i};
    s_next.sync     = s_reg.meta;
    s_next.sck_last = s_reg.sync[0];
  end

  // cs and reset pin idle high so a reset does not fake a select or reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '{meta: 15'h000a, sync: 15'h000a, sck_last: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sck_rise_o    = s_reg.sync[0] & ~s_reg.sck_last;
  assign sck_fall_o    = ~s_reg.sync[0] & s_reg.sck_last;
  assign cs_n_o        = s_reg.sync[1];
  assign si_o          = s_reg.sync[2];
  assign reset_pin_n_o = s_reg.sync[3];
  assign addr_sel_o    = s_reg.sync[6:4];
  assign port_pin_o    = s_reg.sync[14:7];
endmodule

//--- hdl/iox_port_logic.sv
// port logic of the 8-bit i/o expander: registers, pins, interrupt, serial link
module iox_port_logic
  import iox_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic [2:0]  addr_sel_i,
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        si_i,
  output logic             so_o,
  input  wire logic [7:0]  port_pin_i,
  output logic [7:0]       port_pin_o,
  output logic [7:0]       port_pin_oe_n_o,
  output logic [7:0]       pullup_enable_o,
  output logic             int_o,
  output logic             int_oe_n_o,
  output logic             irq_o,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef struct packed {
    logic [7:0]     pin_direction;
    logic [7:0]     input_polarity_invert;
    logic [7:0]     change_interrupt_enable;
    logic [7:0]     compare_default_value;
    logic [7:0]     compare_mode;
    logic [7:0]     device_configuration;
    logic [7:0]     pullup_enable;
    logic [7:0]     int_flag;
    logic [7:0]     interrupt_capture_value;
    logic [7:0]     out_latch;
    logic [7:0]     pin_prev;
    logic [2:0]     addr_code;
    logic           addr_locked;
    iox_phase_type  phase;
    logic [2:0]     bit_cnt;
    logic [7:0]     rx_shift;
    logic [7:0]     tx_shift;
    logic           rd_mode;
    logic [3:0]     pointer;
    logic           so;
    logic [EVT_WIDTH-1:0] evt_status;
    logic [EVT_WIDTH-1:0] evt_mask;
    logic           irq;
    logic           int_pin;
    logic           int_oe_n;
    logic [7:0]     pin_oe_n;
    logic           ready;
    logic           slverr;
    logic [31:0]    rdata;
  } iox_state_type;

  iox_state_type s_reg;
  iox_state_type s_next;

  logic       sck_rise;
  logic       sck_fall;
  logic       cs_n;
  logic       si;
  logic       rst_pin_n;
  logic [2:0] addr_sync;
  logic [7:0] pin_sync;

  // ==========================================================================
  // every pin passes two flops before the logic below looks at it
  iox_sampler u_sampler (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .sck_i         (sck_i),
    .cs_n_i        (cs_n_i),
    .si_i          (si_i),
    .reset_pin_n_i (reset_pin_n_i),
    .addr_sel_i    (addr_sel_i),
    .port_pin_i    (port_pin_i),
    .sck_rise_o    (sck_rise),
    .sck_fall_o    (sck_fall),
    .cs_n_o        (cs_n),
    .si_o          (si),
    .reset_pin_n_o (rst_pin_n),
    .addr_sel_o    (addr_sync),
    .port_pin_o    (pin_sync)
  );

  // ==========================================================================
  // register read mux shared by apb and the serial link
  function automatic logic [7:0] reg_read(input iox_state_type st, input logic [3:0] idx, input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_DIR:       v = st.pin_direction;
      IDX_POLARITY:  v = st.input_polarity_invert;
      IDX_CHG_EN:    v = st.change_interrupt_enable;
      IDX_CMP_DEF:   v = st.compare_default_value;
      IDX_CMP_MODE:  v = st.compare_mode;
      IDX_DEV_CFG:   v = st.device_configuration;
      IDX_PULLUP:    v = st.pullup_enable;
      IDX_INT_FLAG:  v = st.int_flag;
      IDX_INT_CAP:   v = st.interrupt_capture_value;
      IDX_PORT:      v = pins ^ st.input_polarity_invert;
      IDX_OUT_LATCH: v = st.out_latch;
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // writable registers; flag and capture are read only
  function automatic iox_state_type reg_write(input iox_state_type st, input logic [3:0] idx, input logic [7:0] d);
    iox_state_type r;
    r = st;
    case (idx)
      IDX_DIR:       r.pin_direction = d;
      IDX_POLARITY:  r.input_polarity_invert = d;
      IDX_CHG_EN:    r.change_interrupt_enable = d;
      IDX_CMP_DEF:   r.compare_default_value = d;
      IDX_CMP_MODE:  r.compare_mode = d;
      IDX_DEV_CFG:   r.device_configuration = d;
      IDX_PULLUP:    r.pullup_enable = d;
      IDX_PORT:      r.out_latch = d;
      IDX_OUT_LATCH: r.out_latch = d;
      default:       r = st;
    endcase
    return r;
  endfunction

  // pointer step; wraps after the last register, holds when stepping is off
  function automatic logic [3:0] next_ptr(input logic [3:0] p, input logic seq_off);
    logic [3:0] n;
    n = p;
    if (!seq_off) begin
      n = (p >= IDX_LAST) ? 4'h0 : p + 4'h1;
    end
    return n;
  endfunction

  logic                 apb_acc;
  logic                 apb_hit_reg;
  logic [3:0]           apb_idx;
  logic                 clr_pending;
  logic [7:0]           cause;
  logic [7:0]           byte_in;
  logic [7:0]           rd_byte;
  logic                 int_active;
  logic [EVT_WIDTH-1:0] evt_set;

  // ==========================================================================
  // next state of the whole block
  always_comb begin
    s_next      = s_reg;
    evt_set     = '0;
    clr_pending = 1'b0;
    byte_in     = {s_reg.rx_shift[6:0], si};
    rd_byte     = 8'h00;
    apb_idx     = paddr[5:2];
    apb_hit_reg = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) && (apb_idx <= IDX_LAST);
    apb_acc     = psel & penable & s_reg.ready;

    // apb: one wait state, answer registered so every output is a flop
    s_next.ready  = psel & penable & ~s_reg.ready;
    s_next.slverr = 1'b0;
    s_next.rdata  = 32'h0000_0000;
    if (psel && penable && !s_reg.ready) begin
      if (apb_hit_reg) begin
        s_next.rdata = {24'h000000, reg_read(s_reg, apb_idx, pin_sync)};
      end else if (paddr == OFS_EVT_STATUS) begin
        s_next.rdata = {29'h0, s_reg.evt_status};
      end else if (paddr == OFS_EVT_MASK) begin
        s_next.rdata = {29'h0, s_reg.evt_mask};
      end else if (paddr == OFS_ADDR_CODE) begin
        s_next.rdata = {28'h0, s_reg.addr_locked, s_reg.addr_code};
      end else begin
        s_next.slverr = 1'b1;
      end
    end
    if (apb_acc && !pwrite && apb_hit_reg && (apb_idx == IDX_PORT || apb_idx == IDX_INT_CAP)) begin
      clr_pending = 1'b1;
    end
    if (apb_acc && pwrite) begin
      if (apb_hit_reg) begin
        s_next = reg_write(s_next, apb_idx, pwdata[7:0]);
      end else if (paddr == OFS_EVT_MASK) begin
        s_next.evt_mask = pwdata[EVT_WIDTH-1:0];
      end
    end

    // select code follows the pin until the first serial clock, then holds
    if (!s_reg.addr_locked) begin
      s_next.addr_code = addr_sync;
      s_next.addr_locked = sck_rise;
    end

    // serial link, mode 0/3: sample on sck rise, shift out on sck fall
    if (cs_n) begin
      if (s_reg.bit_cnt != 3'h0) begin
        evt_set[EVT_DISCARD] = 1'b1;
      end
      s_next.phase    = PH_OPCODE;
      s_next.bit_cnt  = 3'h0;
      s_next.tx_shift = 8'h00;
      s_next.so       = 1'b0;
    end else begin
      if (sck_fall) begin
        s_next.so       = s_reg.tx_shift[7];
        s_next.tx_shift = {s_reg.tx_shift[6:0], 1'b0};
      end
      if (sck_rise) begin
        s_next.rx_shift = byte_in;
        s_next.bit_cnt  = s_reg.bit_cnt + 3'h1;
        if (s_reg.bit_cnt == 3'h7) begin
          s_next.tx_shift = 8'h00;
          case (s_reg.phase)
            PH_OPCODE: begin
              // only the opcode with our latched code selects this device
              if (byte_in[7:4] == OPCODE_PREFIX && byte_in[3:1] == s_reg.addr_code) begin
                s_next.phase   = PH_ADDR;
                s_next.rd_mode = byte_in[0];
              end else begin
                s_next.phase = PH_IGNORE;
              end
            end
            PH_ADDR: begin
              s_next.phase   = PH_DATA;
              s_next.pointer = byte_in[3:0];
              if (s_reg.rd_mode) begin
                rd_byte = reg_read(s_reg, byte_in[3:0], pin_sync);
                s_next.tx_shift = rd_byte;
                clr_pending = clr_pending | (byte_in[3:0] == IDX_PORT) || (byte_in[3:0] == IDX_INT_CAP);
              end
            end
            PH_DATA: begin
              // a whole byte only: partial bytes never reach this point
              s_next.pointer = next_ptr(s_reg.pointer, s_reg.device_configuration[CFG_SEQ_OFF]);
              if (s_reg.rd_mode) begin
                rd_byte = reg_read(s_reg, s_next.pointer, pin_sync);
                s_next.tx_shift = rd_byte;
                clr_pending = clr_pending | (s_next.pointer == IDX_PORT) || (s_next.pointer == IDX_INT_CAP);
              end else begin
                s_next = reg_write(s_next, s_reg.pointer, byte_in);
                evt_set[EVT_LINK_WR] = 1'b1;
              end
            end
            default: s_next.phase = PH_IGNORE;
          endcase
        end
      end
    end

    // interrupt on change: enabled inputs only, mode chosen per pin
    cause = s_reg.change_interrupt_enable & s_reg.pin_direction &
            ((s_reg.compare_mode & (pin_sync ^ s_reg.compare_default_value)) |
             (~s_reg.compare_mode & (pin_sync ^ s_reg.pin_prev)));
    s_next.pin_prev = pin_sync;
    if (cause != 8'h00 && s_reg.int_flag == 8'h00) begin
      s_next.interrupt_capture_value = pin_sync;
      evt_set[EVT_PIN_INT] = 1'b1;
    end
    // a new cause in the clearing cycle wins over the clear
    s_next.int_flag = (clr_pending ? 8'h00 : s_reg.int_flag) | cause;

    // interrupt pin styles, decided from the next flag state
    int_active = (s_next.int_flag != 8'h00);
    if (s_reg.device_configuration[CFG_INT_ODR]) begin
      s_next.int_pin  = 1'b0;
      s_next.int_oe_n = ~int_active;
    end else begin
      s_next.int_pin  = s_reg.device_configuration[CFG_INT_POL] ? int_active : ~int_active;
      s_next.int_oe_n = 1'b0;
    end

    // pins drive low only where output and latch low, else released
    s_next.pin_oe_n = s_next.pin_direction | s_next.out_latch;

    // block events: sticky, write one to clear, set wins
    s_next.evt_status = s_reg.evt_status;
    if (apb_acc && pwrite && paddr == OFS_EVT_STATUS) begin
      s_next.evt_status = s_reg.evt_status & ~pwdata[EVT_WIDTH-1:0];
    end
    s_next.evt_status = s_next.evt_status | evt_set;
    s_next.irq = |(s_next.evt_status & s_next.evt_mask);
  end

  // ==========================================================================
  // state register; the reset pin joins reset_i after synchronising
  always_ff @(posedge clk_i) begin
    if (reset_i || !rst_pin_n) begin
      s_reg <= '0;
      s_reg.pin_direction <= RST_DIR;
      s_reg.pin_oe_n      <= 8'hff;
      s_reg.int_pin       <= 1'b1;     // idle level of the active-low default
      s_reg.int_oe_n      <= 1'b0;
      s_reg.phase         <= PH_OPCODE;
      s_reg.device_configuration <= RST_REG;
    end else begin
      s_reg <= s_next;
    end
  end

  assign so_o            = s_reg.so;
  assign port_pin_o      = 8'h00 & s_reg.out_latch;
  assign port_pin_oe_n_o = s_reg.pin_oe_n;
  assign pullup_enable_o = s_reg.pullup_enable;
  assign int_o           = s_reg.int_pin;
  assign int_oe_n_o      = s_reg.int_oe_n;
  assign irq_o           = s_reg.irq;
  assign prdata          = s_reg.rdata;
  assign pready          = s_reg.ready;
  assign pslverr         = s_reg.slverr;
endmodule

//--- bench/iox_port_logic_props.sv
// concurrent checks on the pins and apb answers of the expander
module iox_port_logic_props (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        reset_pin_n_i,
  input wire logic        cs_n_i,
  input wire logic        so_o,
  input wire logic [7:0]  port_pin_o,
  input wire logic [7:0]  port_pin_oe_n_o,
  input wire logic        int_o,
  input wire logic        int_oe_n_o,
  input wire logic        irq_o,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // one clock domain, so clocking and disable are stated once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_pins_open_drain: assert property (port_pin_o == 8'h00)
    else $error("port pin driven high");
  a_reset_released: assert property ($fell(reset_i) |-> port_pin_oe_n_o == 8'hff && !irq_o)
    else $error("pins not released after reset");
  a_int_idle: assert property ($fell(reset_i) |-> int_o && !int_oe_n_o)
    else $error("interrupt pin not idle after reset");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_refused_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returns data");
  a_byte_data: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_so_deselected: assert property (cs_n_i [*5] |-> !so_o)
    else $error("serial out active while deselected");
  a_ext_reset: assert property (!reset_pin_n_i [*4] |=> port_pin_oe_n_o == 8'hff && !irq_o)
    else $error("reset pin did not release pins");

  c_refused: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq_o));
  c_so: cover property ($rose(so_o));
  c_int_release: cover property ($rose(int_oe_n_o));
endmodule

bind iox_port_logic iox_port_logic_props props_u (.clk_i, .reset_i, .reset_pin_n_i, .cs_n_i, .so_o, .port_pin_o,
  .port_pin_oe_n_o, .int_o, .int_oe_n_o, .irq_o, .psel, .penable, .pready, .pslverr, .prdata);

//--- bench/iox_host_model.sv
// serial host model: clocks frames into the link and collects read bits
module iox_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: clock low and still, deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // word is {opcode, index, data}; 8 clk per bit gives a 320 ns link clock
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [7:0] rd);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o <= word[31-i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rd = {rd[6:0], so_i};
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // released line must not look held
  endtask
endmodule

//--- bench/iox_port_logic_bench.sv
// self-checking bench for the expander port logic: apb, link frames, pin events
module iox_port_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        reset_pin_n_i = 1'b1;
  logic [2:0]  addr_sel_i = 3'b101;
  logic [7:0]  ext_pins = 8'ha5;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic   sck_i, cs_n_i, si_i, so_o, int_o, int_oe_n_o, irq_o, pready, pslverr;
  wire logic [7:0]  port_pin_i, port_pin_o, port_pin_oe_n_o, pullup_enable_o;
  wire logic [31:0] prdata;
  int          failures = 0;
  int          checks = 0;
  logic [31:0] r;
  logic        e;
  logic [7:0]  sr;
  logic [7:0]  ta [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h28};
  logic [7:0]  tv [7] = '{8'h0f, 8'h3c, 8'h81, 8'h5a, 8'hc3, 8'h99, 8'h50};

  always #20 clk_i = ~clk_i;
  // open drain: a pin pulled low by the block reads low
  assign port_pin_i = ext_pins & port_pin_oe_n_o;

  iox_port_logic dut_u (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .reset_pin_n_i   (reset_pin_n_i),
    .addr_sel_i      (addr_sel_i),
    .sck_i           (sck_i),
    .cs_n_i          (cs_n_i),
    .si_i            (si_i),
    .so_o            (so_o),
    .port_pin_i      (port_pin_i),
    .port_pin_o      (port_pin_o),
    .port_pin_oe_n_o (port_pin_oe_n_o),
    .pullup_enable_o (pullup_enable_o),
    .int_o           (int_o),
    .int_oe_n_o      (int_oe_n_o),
    .irq_o           (irq_o),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr)
  );
  iox_host_model host_u (.clk_i(clk_i), .so_i(so_o), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, x);
  endtask

  task automatic wirq(input logic x);
    int n;
    n = 0;
    while (irq_o !== x && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq_o}, {31'h0, x});
  endtask

  // defaults: direction all ones, port shows the pins, rest zero
  task automatic dflt;
    for (int i = 0; i < 11; i++) rd(8'(i * 4), (i == 0) ? 32'hff : (i == 9) ? {24'h0, ext_pins} : 32'h0);
    rd(8'h44, 32'h0);
    chk(port_pin_oe_n_o, 8'hff);
  endtask

  task automatic results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // test sequence
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    dflt();
    $display("test reset done");
    for (int i = 0; i < 7; i++) wr(ta[i], tv[i]);
    for (int i = 0; i < 7; i++) rd(ta[i], {24'h0, tv[i]});
    chk(pullup_enable_o, 8'h99);
    chk(port_pin_oe_n_o, 8'h5f);
    apb(1'b0, 8'h30, 8'h00);
    chk({31'h0, e}, 32'h1);
    reset_pin_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    dflt();
    wr(8'h20, 8'hff);
    rd(8'h20, 32'h0);
    $display("test registers done");
    wr(8'h04, 8'h0f);
    rd(8'h24, 32'haa);
    wr(8'h04, 8'h00);
    wr(8'h44, 8'h01);
    wr(8'h08, 8'h01);
    ext_pins <= 8'ha4;
    wirq(1'b1);
    chk({31'h0, int_o}, 32'h0);
    rd(8'h1c, 32'h01);
    rd(8'h20, 32'ha4);
    rd(8'h24, 32'ha4);
    rd(8'h1c, 32'h00);
    chk({31'h0, int_o}, 32'h1);
    wr(8'h40, 8'h01);
    wirq(1'b0);
    wr(8'h44, 8'h00);
    ext_pins <= 8'ha5;
    wr(8'h40, 8'h00);
    rd(8'h40, 32'h01);
    chk({31'h0, irq_o}, 32'h0);
    rd(8'h24, 32'ha5);
    wr(8'h40, 8'h07);
    $display("test change done");
    wr(8'h14, 8'h04);
    wr(8'h0c, 8'ha5);
    wr(8'h10, 8'h01);
    wr(8'h44, 8'h01);
    ext_pins <= 8'ha4;
    wirq(1'b1);
    chk({30'h0, int_o, int_oe_n_o}, 32'h0);
    rd(8'h20, 32'ha4);
    wr(8'h14, 8'h02);
    @(posedge clk_i);
    chk({30'h0, int_o, int_oe_n_o}, 32'h2);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    rd(8'h24, 32'ha4);
    wr(8'h40, 8'h07);
    wirq(1'b0);
    $display("test compare done");
    host_u.xfer({8'h4a, 8'h0a, 16'h5577}, 32, sr);
    rd(8'h28, 32'h55);
    rd(8'h00, 32'h77);
    chk(port_pin_oe_n_o, 8'h77);
    host_u.xfer({8'h4b, 8'h00, 16'h0000}, 24, sr);
    chk(sr, 8'h77);
    wr(8'h14, 8'h20);
    host_u.xfer({8'h4a, 8'h06, 16'h1234}, 32, sr);
    rd(8'h18, 32'h34);
    host_u.xfer({8'h48, 8'h06, 16'hee00}, 24, sr);
    rd(8'h18, 32'h34);
    host_u.xfer({8'h4a, 8'h06, 16'hf000}, 20, sr);
    rd(8'h18, 32'h34);
    apb(1'b0, 8'h40, 8'h00);
    chk(r, 32'h6);
    addr_sel_i <= 3'b010;
    rd(8'h48, 32'h0d);
    $display("test link done");
    results();
  end

  // hang guard, far beyond the roughly 1500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
endmodule
